// [include/ddspi_map.vh]
`ifndef DDSPI_MAP_VH
`define DDSPI_MAP_VH
// APB register offsets
`define DDSPI_REG_CTRL 12'h000
`define DDSPI_REG_STAT 12'h004
`define DDSPI_REG_CHAN 12'h008
`define DDSPI_REG_LAST 12'h00C
// Control fields
`define DDSPI_CTRL_ENABLE_BIT 0
`define DDSPI_CTRL_RESET 32'h0000_0000
// Frame fields
`define DDSPI_MODE_HI 15
`define DDSPI_MODE_LO 14
`define DDSPI_PAR_BIT 13
`define DDSPI_WR_BIT 12
`define DDSPI_SEL_BIT 11
`define DDSPI_PROF_BIT 10
`define DDSPI_STR_HI 9
`define DDSPI_STR_LO 8
`define DDSPI_FRAME_BITS 16
// Mode codes
`define DDSPI_MODE_REG 2'b00
`define DDSPI_MODE_CMD 2'b01
`define DDSPI_MODE_DIAG 2'b10
`define DDSPI_MODE_MON 2'b11
// Response headers
`define DDSPI_HDR_REG 3'b000
`define DDSPI_HDR_CMD 3'b010
`define DDSPI_HDR_DIAG 3'b100
`define DDSPI_HDR_MON 3'b110
`define DDSPI_HDR_FAULT 3'b111
// Soft reset keys
`define DDSPI_KEY_FIRST 8'hAA
`define DDSPI_KEY_SECOND 8'h55
// Times in microseconds, clock in MHz
`define DDSPI_CLK_MHZ 100
`define DDSPI_STR0_US 7500
`define DDSPI_STR1_US 15000
`define DDSPI_STR2_US 30000
`define DDSPI_STR3_US 60000
`define DDSPI_LONG_FIRE_US 2000
`define DDSPI_SHORT_FIRE_US 1000
`define DDSPI_STR0_CYC (`DDSPI_STR0_US * `DDSPI_CLK_MHZ)
`define DDSPI_LONG_FIRE_CYC (`DDSPI_LONG_FIRE_US * `DDSPI_CLK_MHZ)
`define DDSPI_SHORT_FIRE_CYC (`DDSPI_SHORT_FIRE_US * `DDSPI_CLK_MHZ)
`endif

// [src/ddspi_decoder.v]
`timescale 1ns/1ps
`include "ddspi_map.vh"
// Behaviour
// [R1] Response to a command shifts out during the next valid chip-select frame.
// [R2] Top two frame bits choose register, command, diagnostic or monitor mode.
// [R3] Response begins with three header bits per mode; fault gives 111.
// [R4] All sixteen bits together must have odd parity; host sets bit 13.
// [R5] Register read ignores low bits; next response holds stretch timer register.
// [R6] Register write: bit 11 clear programs stretch period, set is soft-reset step.
// [R7] Bit 11 clear ignores bits 7..0; set ignores bits 9..8.
// [R8] Bit 10 picks profile: 0 low current long period, 1 high current short.
// [R9] Bits 9..8 pick stretch 7.5/15/30/60 ms; reset value 00.
// [R10] Eight stretch timers, started by arming input or serial deploy command.
// [R11] Soft reset needs consecutive reset writes with low bytes AA then 55.
// [R12] Incomplete sequence within two transfers is discarded without reset.
// [R13] Host must resend the whole sequence after any interruption.
// [R14] Soft reset clears driver logic and timers like power-on, except response.
// [R15] Soft reset frames are ignored while any deployment is in progress.
// [R16] Command bits 7..0 start deployment or stretch timer on matching channel.
// [R17] A zero channel bit cancels that channel's running stretch timer.
// [R18] A started deployment cannot be aborted and runs to completion.
// [R19] Commands to a deploying channel are ignored.
// [R20] Deploy enable low blocks serial start of stretch timer; arming still starts.
// [R21] Running stretch timers ignore later deploy enable changes.
// [R22] Bad parity or length frames are not executed; next response is fault.
// [R23] Frames are sixteen bits, MSB first, exactly sixteen clock edges.
module ddspi_decoder #(
    parameter STR0_CYC = `DDSPI_STR0_CYC,
    parameter LONG_CYC = `DDSPI_LONG_FIRE_CYC,
    parameter SHORT_CYC = `DDSPI_SHORT_FIRE_CYC,
    parameter CH = 8
)
(
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire spi_cs_n,
    input wire spi_sclk,
    input wire spi_mosi,
    output reg spi_miso,
    input wire deploy_enable_input,
    input wire [CH-1:0] arm_in,
    output reg [CH-1:0] fire_on,
    output reg [CH-1:0] stretch_on,
    output reg high_fire_current,
    output reg low_fire_current
);

localparam CW = 32;

function [CW-1:0] str_len;
    input [1:0] sel;
    begin
        str_len = (STR0_CYC << sel) - 1;
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Synchronisers
reg [2:0] cs_s;
reg [2:0] ck_s;
reg [1:0] mo_s;
reg [1:0] en_s;
reg [CH-1:0] arm_m;
reg [CH-1:0] arm_s;
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        cs_s <= 3'h7;
        ck_s <= 3'h0;
        mo_s <= 2'h0;
        en_s <= 2'h0;
        arm_m <= {CH{1'b0}};
        arm_s <= {CH{1'b0}};
    end
    else
    begin
        cs_s <= {cs_s[1:0], spi_cs_n};
        ck_s <= {ck_s[1:0], spi_sclk};
        mo_s <= {mo_s[0], spi_mosi};
        en_s <= {en_s[0], deploy_enable_input};
        arm_m <= arm_in;
        arm_s <= arm_m;
    end
end

wire cs_act = ~cs_s[1];
wire cs_fall = cs_s[2] & ~cs_s[1];
wire cs_rise = ~cs_s[2] & cs_s[1];
wire ck_rise = ~ck_s[2] & ck_s[1];
wire ck_fall = ck_s[2] & ~ck_s[1];

////////////////////////////////////////////////////////////////////////////////
// APB registers
reg [31:0] ctrl;
reg [15:0] last_frame;
reg [15:0] resp;
reg [15:0] shin;
reg [15:0] shout;
reg [4:0] bitcnt;
reg [1:0] str_sel;
reg [1:0] key_state;
reg [CH-1:0] cmd_echo;
reg [CW-1:0] fire_cnt [0:CH-1];
reg [CW-1:0] str_cnt [0:CH-1];
wire blk_en = ctrl[`DDSPI_CTRL_ENABLE_BIT];
wire apb_acc = psel & penable;
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        ctrl <= `DDSPI_CTRL_RESET;
        prdata <= 32'h0000_0000;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end
    else
    begin
        pready <= psel & ~penable;
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
        if (psel & ~penable)
        begin
            case (paddr)
                `DDSPI_REG_CTRL: prdata <= ctrl;
                `DDSPI_REG_STAT: prdata <= {6'h00, high_fire_current, str_sel,
                    key_state, bitcnt, fire_on, stretch_on};
                `DDSPI_REG_CHAN: prdata <= {24'h000000, cmd_echo};
                `DDSPI_REG_LAST: prdata <= {resp, last_frame};
                default: pslverr <= 1'b1;
            endcase
        end
        // Write lands at the access edge that completes the transfer
        if (apb_acc && pready && pwrite && paddr == `DDSPI_REG_CTRL)
            ctrl <= pwdata;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Frame shifting and decode
wire [15:0] fr = shin;
wire [1:0] mode = fr[`DDSPI_MODE_HI:`DDSPI_MODE_LO];
wire par_ok = ^fr; // [R4]
wire len_ok = bitcnt == `DDSPI_FRAME_BITS; // [R23]
wire frame_ok = cs_rise & blk_en & par_ok & len_ok;
wire frame_bad = cs_rise & blk_en & ~(par_ok & len_ok);
wire any_fire = |fire_on;
wire reg_wr = frame_ok && mode == `DDSPI_MODE_REG && fr[`DDSPI_WR_BIT];
wire key_frame = reg_wr & fr[`DDSPI_SEL_BIT];
wire cmd_frame = frame_ok && mode == `DDSPI_MODE_CMD;
wire soft_rst = key_frame & ~any_fire & key_state[0]
    & (fr[7:0] == `DDSPI_KEY_SECOND); // [R11] [R15]
reg [2:0] hdr;
always @*
begin
    case (mode) // [R2] [R3]
        `DDSPI_MODE_REG: hdr = `DDSPI_HDR_REG;
        `DDSPI_MODE_CMD: hdr = `DDSPI_HDR_CMD;
        `DDSPI_MODE_DIAG: hdr = `DDSPI_HDR_DIAG;
        default: hdr = `DDSPI_HDR_MON;
    endcase
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        shin <= 16'h0000;
        shout <= 16'h0000;
        bitcnt <= 5'h00;
        resp <= {`DDSPI_HDR_MON, 13'h0000};
        last_frame <= 16'h0000;
        spi_miso <= 1'b0;
    end
    else
    begin
        if (cs_fall)
        begin
            bitcnt <= 5'h00;
            shout <= resp; // [R1]
            spi_miso <= resp[15];
        end
        else if (cs_act && ck_rise)
        begin
            shin <= {shin[14:0], mo_s[1]}; // [R23]
            if (bitcnt != 5'h1F)
                bitcnt <= bitcnt + 5'h01;
        end
        else if (cs_act && ck_fall)
        begin
            shout <= {shout[14:0], 1'b0};
            spi_miso <= shout[14];
        end
        if (frame_bad)
            resp <= {`DDSPI_HDR_FAULT, 13'h0000}; // [R22]
        else if (frame_ok)
        begin
            last_frame <= fr;
            if (mode == `DDSPI_MODE_REG)
                resp <= {hdr, 2'b00, high_fire_current, str_sel, 8'h00}; // [R5]
            else if (mode == `DDSPI_MODE_CMD)
                resp <= {hdr, 5'h00, cmd_echo};
            else
                resp <= {hdr, 13'h0000};
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Register mode, soft reset, channel timers
integer i;
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        str_sel <= 2'b00; // [R9]
        high_fire_current <= 1'b0; // [R8]
        low_fire_current <= 1'b1;
        key_state <= 2'b00;
        cmd_echo <= {CH{1'b0}};
        fire_on <= {CH{1'b0}};
        stretch_on <= {CH{1'b0}};
        for (i = 0; i < CH; i = i + 1)
        begin
            fire_cnt[i] <= {CW{1'b0}};
            str_cnt[i] <= {CW{1'b0}};
        end
    end
    else if (soft_rst)
    begin
        str_sel <= 2'b00; // [R14]
        high_fire_current <= 1'b0;
        low_fire_current <= 1'b1;
        key_state <= 2'b00;
        cmd_echo <= {CH{1'b0}};
        fire_on <= {CH{1'b0}};
        stretch_on <= {CH{1'b0}};
        for (i = 0; i < CH; i = i + 1)
        begin
            fire_cnt[i] <= {CW{1'b0}};
            str_cnt[i] <= {CW{1'b0}};
        end
    end
    else
    begin
        if (frame_ok || frame_bad)
            key_state <= 2'b00; // [R12] [R13]
        if (key_frame && !any_fire && fr[7:0] == `DDSPI_KEY_FIRST)
            key_state <= 2'b01; // [R11]
        if (reg_wr && !(key_frame && any_fire))
        begin
            high_fire_current <= fr[`DDSPI_PROF_BIT]; // [R8] [R6]
            low_fire_current <= ~fr[`DDSPI_PROF_BIT];
            if (!fr[`DDSPI_SEL_BIT])
                str_sel <= fr[`DDSPI_STR_HI:`DDSPI_STR_LO]; // [R7] [R9]
        end
        if (cmd_frame)
            cmd_echo <= fr[7:0];
        for (i = 0; i < CH; i = i + 1)
        begin
            if (fire_on[i])
            begin
                // Runs out regardless of commands
                if (fire_cnt[i] == {CW{1'b0}})
                    fire_on[i] <= 1'b0; // [R18] [R19]
                else
                    fire_cnt[i] <= fire_cnt[i] - 1'b1;
            end
            else if (stretch_on[i])
            begin
                if (cmd_frame && !fr[i])
                    stretch_on[i] <= 1'b0; // [R17]
                else if (str_cnt[i] == {CW{1'b0}})
                    stretch_on[i] <= 1'b0; // [R21]
                else
                    str_cnt[i] <= str_cnt[i] - 1'b1;
            end
            else if (arm_s[i] || (cmd_frame && fr[i] && en_s[1])) // [R10] [R16] [R20]
            begin
                stretch_on[i] <= 1'b1;
                fire_on[i] <= en_s[1];
                str_cnt[i] <= str_len(str_sel);
                fire_cnt[i] <= high_fire_current ? SHORT_CYC - 1 : LONG_CYC - 1;
            end
        end
    end
end

endmodule // ddspi_decoder

// [tb/ddspi_decoder_asserts.sv]
`timescale 1ns/1ps
module ddspi_decoder_asserts #(parameter STR0_CYC = 40, parameter CH = 8)
(
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    input wire spi_cs_n,
    input wire spi_sclk,
    input wire spi_miso,
    input wire deploy_enable_input,
    input wire [CH-1:0] fire_on,
    input wire [CH-1:0] stretch_on,
    input wire high_fire_current,
    input wire low_fire_current
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    int str_cnt;
    always @(posedge pclk or negedge presetn)
        if (!presetn)
            str_cnt <= 0;
        else
            str_cnt <= stretch_on[0] ? str_cnt + 1 : 0;
    property p_prof; high_fire_current != low_fire_current; endproperty
    a_prof: assert property (p_prof)
        else $error("profile outputs not complementary");
    property p_fire_hold; $rose(fire_on[0]) |-> fire_on[0] [*5]; endproperty
    a_fire_hold: assert property (p_fire_hold)
        else $error("deployment cut short");
    property p_no_fire; !deploy_enable_input [*8] |-> (fire_on & ~$past(fire_on)) == 0;
    endproperty
    a_no_fire: assert property (p_no_fire)
        else $error("deployment started while disabled");
    property p_str_max; str_cnt <= STR0_CYC * 8; endproperty
    a_str_max: assert property (p_str_max)
        else $error("stretch longer than longest period");
    property p_miso; spi_sclk [*6] |-> $stable(spi_miso); endproperty
    a_miso: assert property (p_miso)
        else $error("response bit moved while clock high");
    property p_prof_frame; !spi_cs_n [*5] |-> $stable(high_fire_current); endproperty
    a_prof_frame: assert property (p_prof_frame)
        else $error("profile changed inside a frame");
    property p_slverr; pslverr |-> pready; endproperty
    a_slverr: assert property (p_slverr)
        else $error("error without ready");
    property p_ready; pready |-> psel && penable; endproperty
    a_ready: assert property (p_ready)
        else $error("ready outside access phase");
    c_fire: cover property ($rose(fire_on[0]));
    c_cancel: cover property ($fell(stretch_on[0]));
    c_err: cover property (pslverr);
endmodule // ddspi_decoder_asserts

// [tb/ddspi_host.sv]
`timescale 1ns/1ps
module ddspi_host
(
    input wire pclk,
    input wire miso,
    output reg cs_n = 1'b1,
    output reg sclk = 1'b0,
    output reg mosi = 1'b0,
    output reg done = 1'b0,
    output reg [15:0] rx = 16'h0000
);
    bit busy;
    // Idle data line wanders so stale bits are never trusted
    always @(posedge pclk)
        if (!busy)
            mosi <= ~mosi;
    // MSB first, clock idles low, 16 pclk per bit
    task automatic xfer(input logic [15:0] f);
        busy = 1'b1;
        @(posedge pclk);
        cs_n <= 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            mosi <= f[i];
            repeat (8) @(posedge pclk);
            sclk <= 1'b1;
            rx <= {rx[14:0], miso};
            repeat (8) @(posedge pclk);
            sclk <= 1'b0;
        end
        repeat (8) @(posedge pclk);
        cs_n <= 1'b1;
        done <= 1'b1;
        @(posedge pclk);
        done <= 1'b0;
        busy = 1'b0;
    endtask
endmodule // ddspi_host

// [tb/test_deploy_driver_spi_decoder.sv]
`timescale 1ns/1ps
module test_deploy_driver_spi_decoder;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic en = 1'b1;
    logic [7:0] arm = 8'h00;
    wire [31:0] prdata;
    wire pready, pslverr, cs_n, sclk, mosi, miso, done, hfc, lfc;
    wire [15:0] rx;
    wire [7:0] fire_on, stretch_on;
    int error_cnt = 0;
    int total_checks = 0;
    logic [31:0] expq[$];
    logic [31:0] rd, note;
    logic err;
    logic [7:0] ch;
    ddspi_decoder #(.STR0_CYC(200), .LONG_CYC(40), .SHORT_CYC(20)) ddspi_decoder_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_mosi(mosi), .spi_miso(miso),
        .deploy_enable_input(en), .arm_in(arm), .fire_on(fire_on), .stretch_on(stretch_on),
        .high_fire_current(hfc), .low_fire_current(lfc));
    ddspi_host ddspi_host_i (.pclk(pclk), .miso(miso), .cs_n(cs_n), .sclk(sclk), .mosi(mosi),
        .done(done), .rx(rx));
    initial
        forever #5 pclk = ~pclk;
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task finish_test;
        if (error_cnt == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [15:0] mk(input logic [1:0] m, input logic [12:0] b);
        logic [15:0] f;
        f = {m, 1'b0, b};
        f[13] = ~^f;
        return f;
    endfunction
    // Note holds {mask, value} of the reply due in the following frame
    task send(input logic [15:0] f, input logic [31:0] e);
        expq.push_back(e);
        ddspi_host_i.xfer(f);
        repeat (8) @(posedge pclk);
    endtask
    always @(posedge pclk)
        if (done === 1'b1)
        begin
            note = expq.pop_front();
            chk({16'h0, rx & note[31:16]}, {16'h0, note[15:0]});
        end
    ////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(32'h589F01C9));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        expq.push_back(32'hFFFF_C000);
        apb(1'b1, 12'h000, 32'h0000_0001);
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk(rd & 32'h1, 32'h1);
        apb(1'b0, 12'h010, 32'h0000_0000);
        chk({31'h0, err}, 32'h1);
        send(mk(2'b00, 13'h1500), 32'hE000_0000);
        send(mk(2'b00, 13'h00FF), 32'hE700_0500);
        chk({30'h0, hfc, lfc}, 32'h2);
        ch = 8'($urandom) | 8'h01;
        send(mk(2'b01, {5'h1F, ch}), 32'hE000_4000);
        chk({16'h0, fire_on, stretch_on}, {16'h0, ch, ch});
        send(mk(2'b01, 13'h0000), 32'hE000_4000);
        chk({24'h0, stretch_on}, 32'h0);
        en <= 1'b0;
        send(mk(2'b01, 13'h00FF), 32'hE000_4000);
        chk({24'h0, fire_on | stretch_on}, 32'h0);
        arm <= 8'h04;
        repeat (6) @(posedge pclk);
        arm <= 8'h00;
        en <= 1'b1;
        repeat (12) @(posedge pclk);
        chk({16'h0, fire_on, stretch_on}, 32'h0004);
        send(mk(2'b01, 13'h00FF) ^ 16'h2000, 32'hFFFF_E000);
        chk({24'h0, fire_on}, 32'h0);
        send(mk(2'b10, 13'h0000), 32'hC000_8000);
        send(mk(2'b11, 13'h0000), 32'hE000_C000);
        send(mk(2'b00, 13'h1CAA), 32'hE000_0000);
        send(mk(2'b00, 13'h0000), 32'hE700_0500);
        send(mk(2'b00, 13'h1C55), 32'hE000_0000);
        send(mk(2'b00, 13'h0000), 32'hE700_0500);
        send(mk(2'b00, 13'h1CAA), 32'hE000_0000);
        send(mk(2'b00, 13'h1C55), 32'hE000_0000);
        send(mk(2'b00, 13'h0000), 32'hE300_0000);
        send(mk(2'b11, 13'h0000), 32'h0000_0000);
        finish_test();
    end
    initial
    begin
        #150000;
        error_cnt++;
        finish_test();
    end
endmodule // test_deploy_driver_spi_decoder
bind ddspi_decoder ddspi_decoder_asserts #(.STR0_CYC(STR0_CYC), .CH(CH)) ddspi_decoder_asserts_i (
    .pclk, .presetn, .psel, .penable, .pready, .pslverr, .spi_cs_n, .spi_sclk, .spi_miso,
    .deploy_enable_input, .fire_on, .stretch_on, .high_fire_current, .low_fire_current);
